// [fcr_defines.vh]
`ifndef FCR_DEFINES_VH
`define FCR_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define FCR_ADDR_DIV 12'h000
`define FCR_ADDR_OPT 12'h004
`define FCR_ADDR_KEYCTL 12'h008
`define FCR_ADDR_KEYDAT 12'h00C
`define FCR_ADDR_PECTL 12'h010
`define FCR_ADDR_STAT 12'h014

// ----------------------------------------
// Divider register fields
// ----------------------------------------
`define FCR_DIV_LOADED_BIT 7
`define FCR_DIV_PRESCALE_BIT 6
`define FCR_DIV_FIELD_HI 5
`define FCR_DIV_WR_MASK 7'h7F
`define FCR_PRESCALE_LAST 3'h7

// ----------------------------------------
// Option register fields
// ----------------------------------------
`define FCR_OPT_BACKDOOR_KEY_ENABLE_BIT 7
`define FCR_OPT_NORED_BIT 6
`define FCR_OPT_IMPL_MASK 8'hC3
`define FCR_SEC_UNSECURED 2'h2

// ----------------------------------------
// Own control and status fields
// ----------------------------------------
`define FCR_KEYCTL_ACC_BIT 0
`define FCR_KEYCTL_MISS_BIT 1
`define FCR_KEY_BYTES 4'h8
`define FCR_STAT_BUSY_BIT 0
`define FCR_STAT_REFUSED_BIT 1
`define FCR_STAT_SECURE_BIT 2
`define FCR_STAT_LOADED_BIT 3
`define FCR_BYTE_ZERO 8'h00
`define FCR_WORD_ZERO 32'h0000_0000

`endif

// [fcr_clkdiv.v]
`timescale 1ns/1ps
// ----------------------------------------
// Flash timing clock divider
// ----------------------------------------
module fcr_clkdiv #(
	parameter DIV_W = 6
) (
	input wire clk,
	input wire rst_n,
	input wire run,
	input wire prescale_by_eight,
	input wire [DIV_W-1:0] divisor,
	output reg flash_tick_q
);
`include "fcr_defines.vh"

	reg [2:0] pre_cnt_q;
	reg [DIV_W-1:0] div_cnt_q;
	wire pre_tick;

	assign pre_tick = !prescale_by_eight || (pre_cnt_q == `FCR_PRESCALE_LAST); // (R5)

	always @(posedge clk) begin
		if (!rst_n || !run) begin
			pre_cnt_q <= 3'h0;
			div_cnt_q <= {DIV_W{1'b0}};
			flash_tick_q <= 1'b0;
		end else begin
			pre_cnt_q <= pre_cnt_q + 3'h1; // (R5)
			flash_tick_q <= 1'b0;
			if (pre_tick) begin
				if (div_cnt_q >= divisor) begin // (R6)
					div_cnt_q <= {DIV_W{1'b0}};
					flash_tick_q <= 1'b1;
				end else begin
					div_cnt_q <= div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// [fcr_top.v]
`timescale 1ns/1ps
// Summary of operation
// (R1) Byte-wide registers; option byte copied from nonvolatile store at reset. Code takes and reads back a 16-bit pulse count at PECTL.
// (R2) Divider bit 7 is read-only loaded flag, set by first write after reset.
// (R3) Divider low seven bits always readable, written only by the first write.
// (R4) Program and erase requests refused until the loaded flag is set.
// (R5) Prescale bit 6 selects bus clock divided by eight or undivided.
// (R6) Divider divides its input by divisor field plus one.
// (R7) Software picks settings giving a flash clock of 150 to 200 kHz.
// (R8) Each timing pulse is one flash clock; operations last whole pulse counts.
// (R9) Every reset reloads the working option register from the stored byte.
// (R10) Option register changes only at reset; software reprograms and resets. Code also forces bits 1:0 to unsecured on key or blank unlock.
// (R11) With key enable clear, the backdoor key can never lift security.
// (R12) Key writes honoured only from secure firmware, never background debug.
// (R13) Eight matching key bytes in order lift security until next reset.
// (R14) Option bit 6 set disables vector redirection; clear enables it.
// (R15) Security code 1:0 means unsecured; every other code means secure.
// (R16) While secure, unsecured sources cannot reach RAM or flash contents.
// (R17) Key match or all-blank check sets the working code to unsecured.
// (R18) Blocked writes do nothing; blocked reads return zeros.
// (R19) Option bits 5 to 2 read zero and ignore writes.
module fcr_top #(
	parameter DIV_W = 6,
	parameter CNT_W = 16,
	parameter KEY_N = 8
) (
	input wire clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q,
	input wire bus_src_secure,
	input wire bus_src_debug,
	input wire [7:0] stored_option_byte,
	input wire [8*KEY_N-1:0] stored_unlock_key,
	input wire blank_check_done,
	input wire blank_check_erased,
	input wire mem_req,
	input wire mem_we,
	input wire mem_src_secure,
	input wire [7:0] mem_rdata,
	output reg mem_grant_q,
	output reg mem_we_q,
	output reg [7:0] mem_rdata_q,
	output reg internal_flash_clock_q,
	output reg pe_active_q,
	output reg redirect_disable_q,
	output reg secure_q
);
`include "fcr_defines.vh"

	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	reg divisor_loaded_flag_q;
	reg [6:0] div_field_q;
	reg [7:0] flash_options_q;
	reg key_access_q;
	reg key_mismatch_q;
	reg [3:0] key_idx_q;
	reg [CNT_W-1:0] pulse_cnt_q;
	reg [1:0] state_q;
	reg refused_q;
	reg [1:0] state_d;
	reg [CNT_W-1:0] pulse_cnt_d;
	reg [31:0] rdata_d;
	reg map_hit;
	wire flash_tick;
	wire acc_cycle;
	wire wr_en;
	wire rd_en;
	wire key_src_ok;
	wire key_unlock;
	wire pe_start;
	wire pe_refuse;
	wire is_secure;
	wire [7:0] key_byte;
	wire [7:0] key_bytes [0:KEY_N-1];
	wire sel_div;
	wire sel_keyctl;
	wire sel_keydat;
	wire sel_pectl;
	wire sel_stat;
	wire pe_busy;
	wire pe_allowed;
	wire pe_done;
	wire [CNT_W-1:0] pe_count;
	wire key_full;
	wire key_ready;
	wire key_byte_ok;
	wire blank_unlock;
	wire mem_allowed;
	wire [7:0] div_rd_byte;
	wire [7:0] opt_rd_byte;

	// ----------------------------------------
	// APB access phase
	// ----------------------------------------
	assign acc_cycle = psel && penable && pready_q;
	assign wr_en = acc_cycle && pwrite;
	assign rd_en = psel && penable && !pready_q && !pwrite;

	always @(posedge clk) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= psel && penable && !pready_q;
		end
	end

	// ----------------------------------------
	// Register write decode
	// ----------------------------------------
	assign sel_div = wr_en && (paddr == `FCR_ADDR_DIV);
	assign sel_keyctl = wr_en && (paddr == `FCR_ADDR_KEYCTL);
	assign sel_keydat = wr_en && (paddr == `FCR_ADDR_KEYDAT);
	assign sel_pectl = wr_en && (paddr == `FCR_ADDR_PECTL);
	assign sel_stat = wr_en && (paddr == `FCR_ADDR_STAT);
	assign div_rd_byte = {divisor_loaded_flag_q, div_field_q}; // (R3)
	assign opt_rd_byte = flash_options_q & `FCR_OPT_IMPL_MASK; // (R19)

	// ----------------------------------------
	// Clock divider register
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			divisor_loaded_flag_q <= 1'b0; // (R2)
			div_field_q <= 7'h00;
		end else if (sel_div && !divisor_loaded_flag_q) begin
			divisor_loaded_flag_q <= 1'b1; // (R2)
			div_field_q <= pwdata[6:0] & `FCR_DIV_WR_MASK; // (R3)
		end
	end

	fcr_clkdiv #(
		.DIV_W(DIV_W)
	) u_clkdiv (
		.clk(clk),
		.rst_n(rst_n),
		.run(divisor_loaded_flag_q),
		.prescale_by_eight(div_field_q[`FCR_DIV_PRESCALE_BIT]), // (R5)
		.divisor(div_field_q[`FCR_DIV_FIELD_HI:0]), // (R6)
		.flash_tick_q(flash_tick)
	);

	always @(posedge clk) begin
		if (!rst_n) begin
			internal_flash_clock_q <= 1'b0;
		end else begin
			internal_flash_clock_q <= flash_tick; // (R8)
		end
	end

	// ----------------------------------------
	// Backdoor key compare
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < KEY_N; gi = gi + 1) begin : g_key
			assign key_bytes[gi] = stored_unlock_key[8*gi +: 8];
		end
	endgenerate

	assign key_byte = key_bytes[key_idx_q[2:0]];
	assign key_src_ok = bus_src_secure && !bus_src_debug; // (R12)
	assign key_full = key_idx_q >= `FCR_KEY_BYTES;
	assign key_ready = (key_idx_q == `FCR_KEY_BYTES) && !key_mismatch_q; // (R13)
	assign key_byte_ok = pwdata[7:0] == key_byte; // (R13)
	assign key_unlock = sel_keyctl && key_access_q && !pwdata[`FCR_KEYCTL_ACC_BIT]
		&& key_src_ok && key_ready; // (R13)

	// ----------------------------------------
	// Option register and security
	// ----------------------------------------
	assign is_secure = flash_options_q[1:0] != `FCR_SEC_UNSECURED; // (R15)
	assign blank_unlock = blank_check_done && blank_check_erased; // (R17)

	always @(posedge clk) begin
		if (!rst_n) begin
			flash_options_q <= stored_option_byte & `FCR_OPT_IMPL_MASK; // (R1) (R9) (R19)
		end else if (key_unlock || blank_unlock) begin
			flash_options_q[1:0] <= `FCR_SEC_UNSECURED; // (R17) (R10)
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			redirect_disable_q <= 1'b0;
			secure_q <= 1'b1;
		end else begin
			redirect_disable_q <= flash_options_q[`FCR_OPT_NORED_BIT]; // (R14)
			secure_q <= is_secure; // (R15)
		end
	end

	// ----------------------------------------
	// Backdoor key entry
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			key_access_q <= 1'b0;
			key_mismatch_q <= 1'b0;
			key_idx_q <= 4'h0;
		end else if (sel_keyctl && key_src_ok) begin
			key_access_q <= pwdata[`FCR_KEYCTL_ACC_BIT]
				&& flash_options_q[`FCR_OPT_BACKDOOR_KEY_ENABLE_BIT]; // (R11)
			key_mismatch_q <= 1'b0;
			key_idx_q <= 4'h0;
		end else if (sel_keydat && key_access_q) begin
			if (!key_src_ok || key_full) begin
				key_mismatch_q <= 1'b1; // (R12)
			end else begin
				if (!key_byte_ok) begin
					key_mismatch_q <= 1'b1; // (R13)
				end
				key_idx_q <= key_idx_q + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// Program and erase pulse sequencer
	// ----------------------------------------
	assign pe_busy = state_q == ST_RUN;
	assign pe_allowed = divisor_loaded_flag_q && !pe_busy; // (R4)
	assign pe_count = pwdata[CNT_W-1:0];
	assign pe_done = flash_tick && (pulse_cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}); // (R8)
	assign pe_start = sel_pectl && pe_allowed && (pe_count != {CNT_W{1'b0}}); // (R4)
	assign pe_refuse = sel_pectl && !pe_allowed; // (R4)

	always @* begin
		state_d = state_q;
		pulse_cnt_d = pulse_cnt_q;
		case (state_q)
			ST_IDLE: begin
				if (pe_start) begin
					state_d = ST_RUN;
					pulse_cnt_d = pe_count;
				end
			end
			ST_RUN: begin
				if (flash_tick) begin
					pulse_cnt_d = pulse_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1}; // (R8)
					if (pe_done) begin
						state_d = ST_IDLE;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
				pulse_cnt_d = {CNT_W{1'b0}};
			end
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			pulse_cnt_q <= {CNT_W{1'b0}};
			pe_active_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pulse_cnt_q <= pulse_cnt_d;
			pe_active_q <= state_d == ST_RUN; // (R8)
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			refused_q <= 1'b0;
		end else if (pe_refuse) begin
			refused_q <= 1'b1; // (R4)
		end else if (sel_stat && pwdata[`FCR_STAT_REFUSED_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Secure memory gate
	// ----------------------------------------
	assign mem_allowed = mem_src_secure || !is_secure; // (R16)

	always @(posedge clk) begin
		if (!rst_n) begin
			mem_grant_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_rdata_q <= `FCR_BYTE_ZERO;
		end else begin
			mem_grant_q <= mem_req && mem_allowed; // (R16)
			mem_we_q <= mem_req && mem_we && mem_allowed; // (R18)
			if (mem_allowed) begin
				mem_rdata_q <= mem_rdata;
			end else begin
				mem_rdata_q <= `FCR_BYTE_ZERO; // (R18)
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		rdata_d = `FCR_WORD_ZERO;
		map_hit = 1'b1;
		case (paddr)
			`FCR_ADDR_DIV: rdata_d[7:0] = div_rd_byte; // (R3)
			`FCR_ADDR_OPT: rdata_d[7:0] = opt_rd_byte; // (R19)
			`FCR_ADDR_KEYCTL: begin
				rdata_d[`FCR_KEYCTL_ACC_BIT] = key_access_q;
				rdata_d[`FCR_KEYCTL_MISS_BIT] = key_mismatch_q;
			end
			`FCR_ADDR_KEYDAT: rdata_d = `FCR_WORD_ZERO;
			`FCR_ADDR_PECTL: rdata_d[CNT_W-1:0] = pulse_cnt_q;
			`FCR_ADDR_STAT: begin
				rdata_d[`FCR_STAT_BUSY_BIT] = pe_busy;
				rdata_d[`FCR_STAT_REFUSED_BIT] = refused_q;
				rdata_d[`FCR_STAT_SECURE_BIT] = is_secure;
				rdata_d[`FCR_STAT_LOADED_BIT] = divisor_loaded_flag_q;
			end
			default: map_hit = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			prdata_q <= `FCR_WORD_ZERO;
			pslverr_q <= 1'b0;
		end else if (psel && penable && !pready_q) begin
			prdata_q <= rd_en ? rdata_d : `FCR_WORD_ZERO;
			pslverr_q <= !map_hit;
		end else begin
			pslverr_q <= 1'b0;
		end
	end
endmodule

// [fcr_top_props.sv]
`timescale 1ns/1ps
`include "fcr_defines.vh"
module fcr_top_props (
	input wire clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata_q,
	input wire pready_q,
	input wire pslverr_q,
	input wire [7:0] stored_option_byte,
	input wire mem_req,
	input wire mem_src_secure,
	input wire mem_grant_q,
	input wire mem_we_q,
	input wire [7:0] mem_rdata_q,
	input wire internal_flash_clock_q,
	input wire pe_active_q,
	input wire redirect_disable_q,
	input wire secure_q
);
	reg [7:0] opt_q;
	reg loaded_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	always @(posedge clk) begin
		if (!rst_n) begin
			opt_q <= stored_option_byte & `FCR_OPT_IMPL_MASK;
			loaded_q <= 1'b0;
		end else if (psel && penable && pready_q && pwrite && paddr == `FCR_ADDR_DIV) begin
			loaded_q <= 1'b1;
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_opt_rd;
		pready_q && !pwrite && paddr == `FCR_ADDR_OPT;
	endsequence
	a_one_wait: assert property (s_setup ##1 (psel && penable) |-> !pready_q ##1 pready_q)
		else $error("ready not after one wait state");
	a_err_unmapped: assert property (pready_q && paddr > `FCR_ADDR_STAT |-> pslverr_q && prdata_q == 32'h0)
		else $error("unmapped access not flagged");
	a_opt_fields: assert property (s_opt_rd |-> prdata_q[7:2] == {opt_q[7:6], 4'h0})
		else $error("option register read wrong");
	a_redirect_bit: assert property ($past(rst_n) && $past(rst_n, 2) |-> redirect_disable_q == opt_q[6])
		else $error("redirect output wrong");
	a_sec_decode: assert property (s_opt_rd ##0 prdata_q[1:0] != `FCR_SEC_UNSECURED |-> secure_q)
		else $error("secure code not secure");
	a_mem_block: assert property ((mem_req && !mem_src_secure) ##1 secure_q |-> !mem_grant_q && !mem_we_q
		&& mem_rdata_q == 8'h00)
		else $error("blocked access passed");
	a_mem_grant: assert property (mem_req && mem_src_secure |=> mem_grant_q)
		else $error("secure access not granted");
	a_unloaded_idle: assert property (!loaded_q |-> !internal_flash_clock_q && !pe_active_q)
		else $error("flash clock before divider load");
endmodule
bind fcr_top fcr_top_props u_fcr_top_props (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
	.stored_option_byte(stored_option_byte), .mem_req(mem_req), .mem_src_secure(mem_src_secure),
	.mem_grant_q(mem_grant_q), .mem_we_q(mem_we_q), .mem_rdata_q(mem_rdata_q), .pe_active_q(pe_active_q),
	.internal_flash_clock_q(internal_flash_clock_q), .redirect_disable_q(redirect_disable_q), .secure_q(secure_q));

// [tb.sv]
`timescale 1ns/1ps
`include "fcr_defines.vh"
module tb;
	logic clk, rst_n, psel, penable, pwrite, bus_src_secure, bus_src_debug, blank_check_done, blank_check_erased;
	logic mem_req, mem_we, mem_src_secure, pready_q, pslverr_q, mem_grant_q, mem_we_q, internal_flash_clock_q;
	logic pe_active_q, redirect_disable_q, secure_q, sec, mreq_d, pa;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_q;
	logic [7:0] stored_option_byte, mem_rdata, mem_rdata_q, opt, dv;
	logic [63:0] stored_unlock_key;
	logic [32:0] rq[$];
	logic [9:0] mq[$];
	int miscompares = 0, checks_done = 0, cyc = 0, n, k, p;
	int seed = 32'h2239f270;
	fcr_top u_fcr_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.bus_src_secure(bus_src_secure), .bus_src_debug(bus_src_debug), .stored_option_byte(stored_option_byte),
		.stored_unlock_key(stored_unlock_key), .blank_check_done(blank_check_done),
		.blank_check_erased(blank_check_erased), .mem_req(mem_req), .mem_we(mem_we),
		.mem_src_secure(mem_src_secure), .mem_rdata(mem_rdata), .mem_grant_q(mem_grant_q), .mem_we_q(mem_we_q),
		.mem_rdata_q(mem_rdata_q), .internal_flash_clock_q(internal_flash_clock_q), .pe_active_q(pe_active_q),
		.redirect_disable_q(redirect_disable_q), .secure_q(secure_q));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task check(input string nm, input logic [32:0] s, input logic [32:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task complete_run;
		if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e = 0);
		int t;
		t = 0;
		@(posedge clk);
		if (!w) rq.push_back({a > `FCR_ADDR_STAT, e});
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			t++;
		end while (pready_q !== 1'b1 && t < 50);
		if (t >= 50) miscompares++;
		penable <= 0;
		psel <= 0;
	endtask
	task mem(input logic s, input logic w);
		logic [7:0] r;
		r = $random(seed);
		mq.push_back((sec && !s) ? 10'h0 : {1'b1, w, r});
		mem_rdata <= r;
		mem_req <= 1;
		mem_we <= w;
		mem_src_secure <= s;
		@(posedge clk);
		mem_req <= 0;
		@(posedge clk);
	endtask
	task key(input logic dbg);
		bus_src_debug <= dbg;
		bus_src_secure <= !dbg;
		apb(1, `FCR_ADDR_KEYCTL, 32'h1);
		for (int i = 0; i < 8; i++) apb(1, `FCR_ADDR_KEYDAT, {24'h0, stored_unlock_key[8*i +: 8]});
		apb(1, `FCR_ADDR_KEYCTL, 32'h0);
	endtask
	// ----------------------------------------
	// Result monitor
	// ----------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		mreq_d <= mem_req;
		if (pready_q === 1'b1 && psel && !pwrite) check("prdata", {pslverr_q, prdata_q}, rq.pop_front());
		if (mreq_d === 1'b1) check("mem", {mem_grant_q, mem_we_q, mem_rdata_q}, mq.pop_front());
		if (cyc > 20000) begin
			miscompares++;
			complete_run;
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; bus_src_secure = 1; bus_src_debug = 0;
		blank_check_done = 0; blank_check_erased = 0; mem_req = 0; mem_we = 0; mem_src_secure = 0; mem_rdata = 0;
		mreq_d = 0;
		stored_unlock_key = {$random(seed), $random(seed)};
		for (p = 0; p < 3; p++) begin
			opt = p == 0 ? 8'hBD : p == 1 ? 8'h7C : 8'hDF;
			sec = 1;
			rst_n <= 0;
			stored_option_byte <= opt;
			repeat (12) @(posedge clk);
			rst_n <= 1;
			apb(0, `FCR_ADDR_DIV, 0, 32'h0);
			apb(0, `FCR_ADDR_OPT, 0, opt & 8'hC3);
			apb(1, `FCR_ADDR_OPT, 32'hFF);
			apb(0, `FCR_ADDR_OPT, 0, opt & 8'hC3);
			check("redirect", redirect_disable_q, opt[6]);
			apb(1, `FCR_ADDR_PECTL, 32'h2);
			apb(0, `FCR_ADDR_STAT, 0, 32'h6);
			apb(1, `FCR_ADDR_STAT, 32'h2);
			dv = $random(seed);
			dv[7:6] = {1'b0, p[0]};
			apb(1, `FCR_ADDR_DIV, {24'h0, dv});
			apb(0, `FCR_ADDR_DIV, 0, dv | 8'h80);
			apb(1, `FCR_ADDR_DIV, {24'h0, ~dv});
			apb(0, `FCR_ADDR_DIV, 0, dv | 8'h80);
			apb(0, `FCR_ADDR_STAT, 0, 32'hC);
			for (k = 0; k < 2; k++) begin
				n = 0;
				do begin
					@(posedge clk);
					n++;
				end while (internal_flash_clock_q !== 1'b1 && n < 600);
			end
			check("tick_period", n, (dv[5:0] + 1) * (p[0] ? 8 : 1));
			apb(1, `FCR_ADDR_PECTL, 32'h3);
			n = 0;
			k = 0;
			pa = 0;
			do begin
				@(posedge clk);
				k++;
				if (pa === 1'b1 && internal_flash_clock_q === 1'b1) n++;
				pa = pe_active_q;
			end while ((k < 2 || pe_active_q === 1'b1) && k < 5000);
			check("pe_ticks", n, 3);
			mem(0, 1);
			mem(1, 0);
			key(1);
			apb(0, `FCR_ADDR_STAT, 0, 32'hC);
			key(0);
			sec = !opt[7];
			apb(0, `FCR_ADDR_STAT, 0, sec ? 32'hC : 32'h8);
			apb(0, `FCR_ADDR_OPT, 0, sec ? opt & 8'hC3 : (opt & 8'hC0) | 8'h2);
			for (int e = 0; e < 2; e++) begin
				blank_check_erased <= e[0];
				blank_check_done <= 1;
				@(posedge clk);
				blank_check_done <= 0;
				sec = sec && !e[0];
				@(posedge clk);
				apb(0, `FCR_ADDR_STAT, 0, sec ? 32'hC : 32'h8);
				check("secure", secure_q, sec);
			end
			mem(0, 1);
			apb(0, 12'h020, 0, 32'h0);
		end
		@(posedge clk);
		if (rq.size() != 0 || mq.size() != 0) miscompares++;
		complete_run;
	end
endmodule
